/* File: rtl/pms_pkg.sv */
package pms_pkg;

   // Register bus geometry: byte address = {channel, index, 2'b00}
   localparam int            ADDR_W        = 8;
   localparam int            DATA_W        = 32;
   localparam int            IDX_W         = 5;
   localparam int            IDX_LSB       = 2;
   localparam int            CH_BIT        = 7;

   // Register indices (byte address is four times the index)
   localparam logic [4:0]    IDX_FR1       = 5'h01;
   localparam logic [4:0]    IDX_CFR       = 5'h03;
   localparam logic [4:0]    IDX_FTW0      = 5'h04;
   localparam logic [4:0]    IDX_POW0      = 5'h05;
   localparam logic [4:0]    IDX_AMP0      = 5'h06;
   localparam logic [4:0]    IDX_WORD1     = 5'h0A;
   localparam logic [4:0]    IDX_WORD15    = 5'h18;
   localparam logic [4:0]    IDX_STATUS    = 5'h1F;

   // Field positions
   localparam int            CFR_TYPE_LSB  = 22;
   localparam int            CFR_SWEEP_BIT = 14;
   localparam int            FR1_LEVEL_LSB = 8;
   localparam int            FR1_RAMP_LSB  = 10;
   localparam int            FR1_PPC_LSB   = 12;
   localparam int            ST_ACTIVE_BIT = 4;
   localparam int            ST_RAMP_BIT   = 5;
   localparam int            ST_DOWN_BIT   = 6;

   // Resolutions, MSB aligned inside a 32-bit profile word
   localparam int            FREQ_W        = 32;
   localparam int            PHASE_W       = 14;
   localparam int            AMPL_W        = 10;
   localparam int            NUM_WORDS     = 16;
   localparam int            SEL_W         = 4;

   // Pin-assignment codes
   localparam logic [2:0]    PPC_FOUR      = 3'h5;
   localparam logic [1:0]    PPC_CH0       = 2'h2;
   localparam logic [1:0]    PPC_CH1       = 2'h3;

   // Reset values
   localparam logic [31:0]   FR1_RESET     = 32'h0;
   localparam logic [31:0]   CFR_RESET     = 32'h0;
   localparam logic [31:0]   WORD_RESET    = 32'h0;

   // Synchroniser width: four profile pins plus three aux ramp pins
   localparam int            SYNC_BITS     = 7;

   typedef enum logic [1:0] {TYPE_OFF, TYPE_AMPL, TYPE_FREQ, TYPE_PHASE} pms_type_e;
   typedef enum logic [1:0] {LVL_2, LVL_4, LVL_8, LVL_16} pms_level_e;
   typedef enum logic [1:0] {RAMP_OFF, RAMP_P23, RAMP_P3, RAMP_SERIAL} pms_ramp_e;

endpackage : pms_pkg

/* File: rtl/pms_profile_select.sv */
// Local design decision: strobed register access.
`timescale 1ns/1ps
module pms_profile_select
   import pms_pkg::*;
(
   input  wire logic                 clk_i,
   input  wire logic                 rst_i,
   input  wire logic [ADDR_W-1:0]    addr_i,
   input  wire logic [DATA_W-1:0]    wdata_i,
   input  wire logic                 wr_i,
   input  wire logic                 rd_i,
   output logic      [DATA_W-1:0]    rdata_o,
   input  wire logic [3:0]           profile_pin_i,
   input  wire logic [3:1]           aux_ramp_pin_i,
   output logic      [FREQ_W-1:0]    ch0_freq_o,
   output logic      [PHASE_W-1:0]   ch0_phase_o,
   output logic      [AMPL_W-1:0]    ch0_ampl_o,
   output logic      [SEL_W-1:0]     ch0_word_index_o,
   output logic                      ch0_ramp_en_o,
   output logic                      ch0_ramp_down_o,
   output logic      [FREQ_W-1:0]    ch1_freq_o,
   output logic      [PHASE_W-1:0]   ch1_phase_o,
   output logic      [AMPL_W-1:0]    ch1_ampl_o,
   output logic      [SEL_W-1:0]     ch1_word_index_o,
   output logic                      ch1_ramp_en_o,
   output logic                      ch1_ramp_down_o,
   output logic                      serial_one_bit_o
);

   typedef struct packed {
      logic [SYNC_BITS-1:0]                          sync1;
      logic [SYNC_BITS-1:0]                          sync2;
      logic [SYNC_BITS-1:0]                          sync3;
      logic [SYNC_BITS-1:0]                          pins;
      logic [31:0]                                   fr1;
      logic [1:0][31:0]                              channel_function_reg;
      logic [1:0][NUM_WORDS-1:0][31:0]               word;
      logic [1:0][PHASE_W-1:0]                       pow0;
      logic [1:0][AMPL_W-1:0]                        amp0;
      logic [1:0][SEL_W-1:0]                         sel;
      logic [1:0]                                    ramp_en;
      logic [1:0]                                    ramp_dn;
      logic [1:0]                                    active;
      logic [1:0][FREQ_W-1:0]                        freq;
      logic [1:0][PHASE_W-1:0]                       phase;
      logic [1:0][AMPL_W-1:0]                        ampl;
      logic [1:0][SEL_W-1:0]                         idx_q;
      logic [1:0]                                    ramp_en_q;
      logic [1:0]                                    ramp_dn_q;
      logic [1:0]                                    active_q;
      logic [DATA_W-1:0]                             rdata;
   } pms_state_s;

   pms_state_s st;
   pms_state_s next_st;

   // Next-state logic: bus slave, pin filter, decode stage, output stage
   always_comb
   begin
      logic [IDX_W-1:0]   idx;
      logic               ch;
      logic [4:0]         slot;
      logic [3:0]         p;
      logic [3:1]         sd;
      pms_level_e         lvl;
      pms_ramp_e          rmp;
      logic [2:0]         pin_assign_config;
      logic [1:0][3:0]    sel_v;
      logic [1:0]         ren_v;
      logic [1:0]         rdn_v;
      logic [1:0]         act_v;
      pms_type_e          typ;
      logic [31:0]        w;
      logic [31:0]        stat;

      next_st = st;
      idx     = addr_i[IDX_LSB +: IDX_W];
      ch      = addr_i[CH_BIT];
      slot    = idx - (IDX_WORD1 - 5'h01);
      p       = st.pins[3:0];
      sd      = st.pins[6:4];
      lvl     = pms_level_e'(st.fr1[FR1_LEVEL_LSB +: 2]);
      pin_assign_config     = st.fr1[FR1_PPC_LSB +: 3];
      rmp     = pms_ramp_e'(st.fr1[FR1_RAMP_LSB +: 2]);
      sel_v   = '0;
      ren_v   = '0;
      rdn_v   = '0;
      act_v   = '0;
      typ     = TYPE_OFF;
      w       = '0;
      stat    = '0;

      // Three-stage pin synchroniser; a bit moves once stages two and three agree
      next_st.sync1 = {aux_ramp_pin_i, profile_pin_i};
      next_st.sync2 = st.sync1;
      next_st.sync3 = st.sync2;
      for (int b = 0; b < SYNC_BITS; b++)
      begin
         if (st.sync2[b] == st.sync3[b])
         begin
            next_st.pins[b] = st.sync3[b];
         end
      end

      // Pin-to-channel decode; pin zero is the index MSB
      unique case (rmp)
         RAMP_P23:
         begin
            // Only two levels here; both channels ramp, pins two and three set the ramp direction
            sel_v[0] = {3'h0, p[0]};
            sel_v[1] = {3'h0, p[1]};
            ren_v    = 2'b11;
            rdn_v    = {p[3], p[2]};
         end
         RAMP_P3:
         begin
            // Only eight levels here; the owning channel ramps, pin three sets its direction
            if (pin_assign_config[1:0] == PPC_CH0 || pin_assign_config[1:0] == PPC_CH1)
            begin
               sel_v[pin_assign_config[0]] = {1'b0, p[0], p[1], p[2]};
               ren_v[pin_assign_config[0]] = 1'b1;
               rdn_v[pin_assign_config[0]] = p[3];
            end
         end
         default:
         begin
            unique case (lvl)
               LVL_2:
               begin
                  sel_v[0] = {3'h0, p[2]};
                  sel_v[1] = {3'h0, p[3]};
               end
               LVL_4:
               begin
                  if (pin_assign_config == PPC_FOUR)
                  begin
                     sel_v[0] = {2'h0, p[0], p[1]};
                     sel_v[1] = {2'h0, p[2], p[3]};
                  end
               end
               LVL_8:
               begin
                  if (pin_assign_config[1:0] == PPC_CH0 || pin_assign_config[1:0] == PPC_CH1)
                  begin
                     sel_v[pin_assign_config[0]] = {1'b0, p[0], p[1], p[2]};
                  end
               end
               LVL_16:
               begin
                  // All four pins go to one channel; the other stays on word 0
                  if (pin_assign_config[1:0] == PPC_CH0 || pin_assign_config[1:0] == PPC_CH1)
                  begin
                     sel_v[pin_assign_config[0]] = {p[0], p[1], p[2], p[3]};
                  end
               end
            endcase
            // Serial pins only ever ramp, they never feed a word index
            if (rmp == RAMP_SERIAL)
            begin
               unique case (lvl)
                  LVL_2:
                  begin
                     ren_v[sd[2]] = sd[1];
                     rdn_v[sd[2]] = sd[3];
                  end
                  LVL_4:
                  begin
                     ren_v = 2'b11;
                     rdn_v = {sd[2], sd[1]};
                  end
                  LVL_16:
                  begin
                     if (pin_assign_config[1:0] == PPC_CH0 || pin_assign_config[1:0] == PPC_CH1)
                     begin
                        ren_v[pin_assign_config[0]] = 1'b1;
                        rdn_v[pin_assign_config[0]] = sd[1];
                     end
                  end
                  default:
                  begin
                     ren_v = 2'b00;
                  end
               endcase
            end
         end
      endcase

      // Per-channel gating by type and sweep bit
      for (int c = 0; c < 2; c++)
      begin
         typ = pms_type_e'(st.channel_function_reg[c][CFR_TYPE_LSB +: 2]);
         // A channel in sweep mode is left on word 0; the host keeps sweep clear
         act_v[c] = (typ != TYPE_OFF) && !st.channel_function_reg[c][CFR_SWEEP_BIT];
         next_st.active[c]  = act_v[c];
         next_st.sel[c]     = act_v[c] ? sel_v[c] : 4'h0;
         // Amplitude keying already owns the scaler, so ramping is blocked
         next_st.ramp_en[c] = ren_v[c] && (typ == TYPE_FREQ || typ == TYPE_PHASE);
         next_st.ramp_dn[c] = rdn_v[c];
      end

      // Output stage: same depth for both channels
      for (int c = 0; c < 2; c++)
      begin
         typ = pms_type_e'(st.channel_function_reg[c][CFR_TYPE_LSB +: 2]);
         w   = st.word[c][st.sel[c]];
         next_st.freq[c]  = (typ == TYPE_FREQ) ? w : st.word[c][0];
         next_st.phase[c] = (typ == TYPE_PHASE && st.sel[c] != 4'h0)
                            ? w[31 -: PHASE_W] : st.pow0[c];
         next_st.ampl[c]  = (typ == TYPE_AMPL && st.sel[c] != 4'h0)
                            ? w[31 -: AMPL_W] : st.amp0[c];
         next_st.idx_q[c]     = st.sel[c];
         next_st.ramp_en_q[c] = st.ramp_en[c];
         next_st.ramp_dn_q[c] = st.ramp_dn[c];
         next_st.active_q[c]  = st.active[c];
      end

      // Register writes
      if (wr_i)
      begin
         if (idx == IDX_FR1)
         begin
            next_st.fr1 = wdata_i;
         end
         else if (idx == IDX_CFR)
         begin
            next_st.channel_function_reg[ch] = wdata_i;
         end
         else if (idx == IDX_FTW0)
         begin
            next_st.word[ch][0] = wdata_i;
         end
         else if (idx == IDX_POW0)
         begin
            next_st.pow0[ch] = wdata_i[PHASE_W-1:0];
         end
         else if (idx == IDX_AMP0)
         begin
            next_st.amp0[ch] = wdata_i[AMPL_W-1:0];
         end
         else if (idx >= IDX_WORD1 && idx <= IDX_WORD15)
         begin
            next_st.word[ch][slot[3:0]] = wdata_i;
         end
      end

      // Read data stand for exactly one cycle after the strobe
      stat[SEL_W-1:0]    = st.idx_q[ch];
      stat[ST_ACTIVE_BIT] = st.active_q[ch];
      stat[ST_RAMP_BIT]   = st.ramp_en_q[ch];
      stat[ST_DOWN_BIT]   = st.ramp_dn_q[ch];
      next_st.rdata = '0;
      if (rd_i)
      begin
         if (idx == IDX_FR1)
         begin
            next_st.rdata = st.fr1;
         end
         else if (idx == IDX_CFR)
         begin
            next_st.rdata = st.channel_function_reg[ch];
         end
         else if (idx == IDX_FTW0)
         begin
            next_st.rdata = st.word[ch][0];
         end
         else if (idx == IDX_POW0)
         begin
            next_st.rdata = {18'h0, st.pow0[ch]};
         end
         else if (idx == IDX_AMP0)
         begin
            next_st.rdata = {22'h0, st.amp0[ch]};
         end
         else if (idx >= IDX_WORD1 && idx <= IDX_WORD15)
         begin
            next_st.rdata = st.word[ch][slot[3:0]];
         end
         else if (idx == IDX_STATUS)
         begin
            next_st.rdata = stat;
         end
      end
   end

   // State register
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         st      <= '0;
         st.fr1  <= FR1_RESET;
         st.channel_function_reg  <= {2{CFR_RESET}};
         st.word <= {(2 * NUM_WORDS){WORD_RESET}};
      end
      else
      begin
         st <= next_st;
      end
   end

   // Outputs straight from flip-flops
   assign rdata_o          = st.rdata;
   assign ch0_freq_o       = st.freq[0];
   assign ch0_phase_o      = st.phase[0];
   assign ch0_ampl_o       = st.ampl[0];
   assign ch0_word_index_o = st.idx_q[0];
   assign ch0_ramp_en_o    = st.ramp_en_q[0];
   assign ch0_ramp_down_o  = st.ramp_dn_q[0];
   assign ch1_freq_o       = st.freq[1];
   assign ch1_phase_o      = st.phase[1];
   assign ch1_ampl_o       = st.ampl[1];
   assign ch1_word_index_o = st.idx_q[1];
   assign ch1_ramp_en_o    = st.ramp_en_q[1];
   assign ch1_ramp_down_o  = st.ramp_dn_q[1];
   // Serial port limited to one data line while serial pins ramp
   assign serial_one_bit_o = (st.fr1[FR1_RAMP_LSB +: 2] == 2'h3);

endmodule : pms_profile_select

/* File: testbench/pms_props.sv */
`timescale 1ns/1ps
module pms_props
   import pms_pkg::*;
(
   input wire logic              clk_i,
   input wire logic              rst_i,
   input wire logic [ADDR_W-1:0] addr_i,
   input wire logic [DATA_W-1:0] wdata_i,
   input wire logic              wr_i,
   input wire logic              rd_i,
   input wire logic [DATA_W-1:0] rdata_o,
   input wire logic [3:0]        profile_pin_i,
   input wire logic [3:1]        aux_ramp_pin_i,
   input wire logic [SEL_W-1:0]  ch0_word_index_o,
   input wire logic [SEL_W-1:0]  ch1_word_index_o,
   input wire logic              ch0_ramp_en_o,
   input wire logic              ch1_ramp_en_o,
   input wire logic              serial_one_bit_o
);
   logic [3:0] up_cnt;
   // Quiet checks wait until the decode pipeline has settled after reset
   always_ff @(posedge clk_i or posedge rst_i)
      if (rst_i)
         up_cnt <= 4'h0;
      else if (up_cnt != 4'hF)
         up_cnt <= up_cnt + 4'h1;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   property p_rd_idle;
      !$past(rd_i) |-> rdata_o == 32'h0;
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
   property p_unmapped;
      rd_i && addr_i[6:2] inside {5'h00, 5'h02, [5'h07:5'h09], [5'h19:5'h1E]}
         |=> rdata_o == 32'h0;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   property p_fr1_rb;
      wr_i && addr_i[6:2] == IDX_FR1 ##1 !wr_i ##1 rd_i && addr_i[6:2] == IDX_FR1
         |=> (rdata_o & 32'h00007F00) == ($past(wdata_i, 3) & 32'h00007F00);
   endproperty
   a_fr1_rb: assert property (p_fr1_rb) else $error("fr1 fields lost");
   property p_ser_on;
      wr_i && addr_i[6:2] == IDX_FR1 && wdata_i[11:10] == 2'h3 |-> ##[1:2] serial_one_bit_o;
   endproperty
   a_ser_on: assert property (p_ser_on) else $error("serial mode not forced");
   property p_ser_off;
      wr_i && addr_i[6:2] == IDX_FR1 && wdata_i[11:10] != 2'h3 |-> ##[1:2] !serial_one_bit_o;
   endproperty
   a_ser_off: assert property (p_ser_off) else $error("serial mode stuck");
   property p_ser_cause;
      $changed(serial_one_bit_o) |-> $past(wr_i) || $past(wr_i, 2);
   endproperty
   a_ser_cause: assert property (p_ser_cause) else $error("serial mode moved alone");
   property p_quiet;
      (up_cnt == 4'hF && !wr_i && $stable(profile_pin_i) && $stable(aux_ramp_pin_i))[*7]
         |=> $stable(ch0_word_index_o) && $stable(ch1_word_index_o)
            && $stable(ch0_ramp_en_o) && $stable(ch1_ramp_en_o);
   endproperty
   a_quiet: assert property (p_quiet) else $error("outputs moved without cause");
   property p_aux_no_idx;
      (up_cnt == 4'hF && !wr_i && $stable(profile_pin_i))[*7]
         |=> $stable(ch0_word_index_o) && $stable(ch1_word_index_o);
   endproperty
   a_aux_no_idx: assert property (p_aux_no_idx) else $error("aux pin moved index");
endmodule : pms_props

bind pms_profile_select pms_props u_props (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i),
   .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
   .profile_pin_i(profile_pin_i), .aux_ramp_pin_i(aux_ramp_pin_i),
   .ch0_word_index_o(ch0_word_index_o), .ch1_word_index_o(ch1_word_index_o),
   .ch0_ramp_en_o(ch0_ramp_en_o), .ch1_ramp_en_o(ch1_ramp_en_o),
   .serial_one_bit_o(serial_one_bit_o));

/* File: testbench/pms_pin_ctrl.sv */
`timescale 1ns/1ps
module pms_pin_ctrl
(
   input  wire logic       clk_i,
   input  wire logic [3:0] pin_cmd_i,
   input  wire logic [2:0] aux_cmd_i,
   output logic      [3:0] profile_pin_o,
   output logic      [3:1] aux_ramp_pin_o
);
   // Pins move on the rising edge; the device still sees them only through its filter
   always @(posedge clk_i)
   begin
      profile_pin_o  <= pin_cmd_i;
      aux_ramp_pin_o <= aux_cmd_i;
   end
endmodule : pms_pin_ctrl

/* File: testbench/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
   import pms_pkg::*;
   logic              clk_i, rst_i, wr_i, rd_i, en0, en1, dn0, dn1, ser;
   logic [ADDR_W-1:0] addr_i;
   logic [DATA_W-1:0] wdata_i, rdata_o, f0, f1;
   logic [3:0]        cmd_pin, pin, idx0, idx1;
   logic [2:0]        cmd_aux;
   logic [3:1]        aux;
   logic [13:0]       p0, p1;
   logic [9:0]        m0, m1;
   int                err_total = 0;
   int                n_checks = 0;
   int                cyc = 0;
   pms_pin_ctrl partner (.clk_i(clk_i), .pin_cmd_i(cmd_pin), .aux_cmd_i(cmd_aux),
      .profile_pin_o(pin), .aux_ramp_pin_o(aux));
   pms_profile_select uut (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
      .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .profile_pin_i(pin), .aux_ramp_pin_i(aux),
      .ch0_freq_o(f0), .ch0_phase_o(p0), .ch0_ampl_o(m0), .ch0_word_index_o(idx0),
      .ch0_ramp_en_o(en0), .ch0_ramp_down_o(dn0), .ch1_freq_o(f1), .ch1_phase_o(p1),
      .ch1_ampl_o(m1), .ch1_word_index_o(idx1), .ch1_ramp_en_o(en1), .ch1_ramp_down_o(dn1),
      .serial_one_bit_o(ser));
   task end_sim;
      $display("checks %0d errors %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : end_sim
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e)
      begin
         $display("Error %s expected %h seen %h", nm, e, g);
         err_total++;
      end
   endtask : chk
   task wr(input logic c, input logic [4:0] x, input logic [31:0] d);
      @(posedge clk_i);
      addr_i  <= {c, x, 2'h0};
      wdata_i <= d;
      wr_i    <= 1'b1;
      @(posedge clk_i);
      wr_i    <= 1'b0;
   endtask : wr
   task rd(input logic c, input logic [4:0] x, input logic [31:0] e);
      @(posedge clk_i);
      addr_i <= {c, x, 2'h0};
      rd_i   <= 1'b1;
      @(posedge clk_i);
      rd_i   <= 1'b0;
      #1;
      chk("rdata", e, rdata_o);
   endtask : rd
   // Low bits of every word are nonzero, so ignoring them is exercised too
   function automatic logic [31:0] wv(input logic c, input logic [3:0] i);
      return {i, 3'h0, c, 24'hA5C396};
   endfunction : wv
   function automatic logic [31:0] ev(input logic c, input logic [3:0] i, input pms_type_e t);
      logic [31:0] w;
      w = wv(c, i);
      if (t == TYPE_PHASE)
         return (i == 4'h0) ? {18'h0, w[13:0]} : {18'h0, w[31:18]};
      if (t == TYPE_AMPL)
         return (i == 4'h0) ? {22'h0, w[9:0]} : {22'h0, w[31:22]};
      return w;
   endfunction : ev
   // Host side: sweep bit always clear, unused channel typed off by the caller
   task mode(input logic [1:0] lv, input logic [1:0] rp, input logic [2:0] pc,
      input pms_type_e t0, input pms_type_e t1, input logic [3:0] pn, input logic [2:0] ax);
      wr(1'b0, IDX_FR1, {17'h0, pc, rp, lv, 8'h00});
      wr(1'b0, IDX_CFR, {8'h00, t0, 22'h0});
      wr(1'b1, IDX_CFR, {8'h00, t1, 22'h0});
      cmd_pin <= pn;
      cmd_aux <= ax;
      repeat (12) @(posedge clk_i);
      #1;
   endtask : mode
   task chkch(input logic c, input pms_type_e t, input logic [3:0] ei, input logic een,
      input logic edn);
      logic [31:0] v;
      if (t == TYPE_PHASE)
         v = c ? {18'h0, p1} : {18'h0, p0};
      else if (t == TYPE_AMPL)
         v = c ? {22'h0, m1} : {22'h0, m0};
      else
         v = c ? f1 : f0;
      chk("index", {28'h0, ei}, {28'h0, c ? idx1 : idx0});
      chk("value", ev(c, (t == TYPE_OFF) ? 4'h0 : ei, t), v);
      chk("ramp_en", {31'h0, een}, {31'h0, c ? en1 : en0});
      if (een)
         chk("ramp_down", {31'h0, edn}, {31'h0, c ? dn1 : dn0});
   endtask : chkch
   initial
   begin
      clk_i = 1'b0;
      forever #4 clk_i = ~clk_i;
   end
   // Hang guard, far beyond the length of the sequence
   always @(posedge clk_i)
   begin
      cyc <= cyc + 1;
      if (cyc == 5000)
      begin
         err_total++;
         end_sim;
      end
   end
   initial
   begin
      rst_i = 1'b1;
      {wr_i, rd_i, addr_i, wdata_i, cmd_pin, cmd_aux} = '0;
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(1'b0, IDX_FR1, 32'h0);
      rd(1'b1, IDX_CFR, 32'h0);
      rd(1'b0, IDX_WORD15, 32'h0);
      for (int c = 0; c < 2; c++)
      begin
         wr(c[0], IDX_FTW0, wv(c[0], 4'h0));
         wr(c[0], IDX_POW0, wv(c[0], 4'h0));
         wr(c[0], IDX_AMP0, wv(c[0], 4'h0));
         for (int i = 1; i < 16; i++)
            wr(c[0], IDX_WORD1 + 5'(i - 1), wv(c[0], 4'(i)));
      end
      rd(1'b1, IDX_POW0, ev(1'b1, 4'h0, TYPE_PHASE));
      rd(1'b1, IDX_AMP0, ev(1'b1, 4'h0, TYPE_AMPL));
      rd(1'b1, IDX_WORD15, wv(1'b1, 4'hF));
      wr(1'b0, 5'h07, 32'hFFFFFFFF);
      rd(1'b0, 5'h07, 32'h0);
      wr(1'b0, IDX_FR1, 32'h00005A00);
      rd(1'b0, IDX_FR1, 32'h00005A00);
      mode(LVL_2, RAMP_OFF, 3'h0, TYPE_FREQ, TYPE_PHASE, 4'h4, 3'h0);
      chkch(1'b0, TYPE_FREQ, 4'h1, 1'b0, 1'b0);
      chkch(1'b1, TYPE_PHASE, 4'h0, 1'b0, 1'b0);
      chk("serial", 32'h0, {31'h0, ser});
      mode(LVL_2, RAMP_OFF, 3'h6, TYPE_FREQ, TYPE_PHASE, 4'hB, 3'h0);
      chkch(1'b0, TYPE_FREQ, 4'h0, 1'b0, 1'b0);
      chkch(1'b1, TYPE_PHASE, 4'h1, 1'b0, 1'b0);
      mode(LVL_4, RAMP_OFF, PPC_FOUR, TYPE_FREQ, TYPE_AMPL, 4'hB, 3'h0);
      chkch(1'b0, TYPE_FREQ, 4'h3, 1'b0, 1'b0);
      chkch(1'b1, TYPE_AMPL, 4'h1, 1'b0, 1'b0);
      mode(LVL_4, RAMP_OFF, PPC_FOUR, TYPE_FREQ, TYPE_AMPL, 4'h6, 3'h0);
      chkch(1'b0, TYPE_FREQ, 4'h1, 1'b0, 1'b0);
      chkch(1'b1, TYPE_AMPL, 4'h2, 1'b0, 1'b0);
      mode(LVL_8, RAMP_OFF, 3'h2, TYPE_PHASE, TYPE_OFF, 4'hB, 3'h0);
      chkch(1'b0, TYPE_PHASE, 4'h6, 1'b0, 1'b0);
      mode(LVL_8, RAMP_OFF, 3'h2, TYPE_PHASE, TYPE_OFF, 4'h3, 3'h0);
      chkch(1'b0, TYPE_PHASE, 4'h6, 1'b0, 1'b0);
      mode(LVL_8, RAMP_OFF, 3'h7, TYPE_OFF, TYPE_FREQ, 4'h4, 3'h0);
      chkch(1'b1, TYPE_FREQ, 4'h1, 1'b0, 1'b0);
      mode(LVL_16, RAMP_OFF, 3'h3, TYPE_OFF, TYPE_FREQ, 4'h7, 3'h0);
      chkch(1'b1, TYPE_FREQ, 4'hE, 1'b0, 1'b0);
      chkch(1'b0, TYPE_OFF, 4'h0, 1'b0, 1'b0);
      mode(LVL_16, RAMP_OFF, 3'h6, TYPE_AMPL, TYPE_OFF, 4'hB, 3'h0);
      chkch(1'b0, TYPE_AMPL, 4'hD, 1'b0, 1'b0);
      mode(LVL_2, RAMP_P23, PPC_FOUR, TYPE_FREQ, TYPE_PHASE, 4'h5, 3'h0);
      chkch(1'b0, TYPE_FREQ, 4'h1, 1'b1, 1'b1);
      chkch(1'b1, TYPE_PHASE, 4'h0, 1'b1, 1'b0);
      mode(LVL_2, RAMP_P23, PPC_FOUR, TYPE_AMPL, TYPE_PHASE, 4'h5, 3'h0);
      chkch(1'b0, TYPE_AMPL, 4'h1, 1'b0, 1'b0);
      mode(LVL_8, RAMP_P3, 3'h2, TYPE_PHASE, TYPE_OFF, 4'h5, 3'h0);
      chkch(1'b0, TYPE_PHASE, 4'h5, 1'b1, 1'b0);
      mode(LVL_8, RAMP_P3, 3'h7, TYPE_OFF, TYPE_FREQ, 4'hE, 3'h0);
      chkch(1'b1, TYPE_FREQ, 4'h3, 1'b1, 1'b1);
      mode(LVL_2, RAMP_SERIAL, 3'h0, TYPE_FREQ, TYPE_FREQ, 4'h4, 3'h3);
      chk("serial", 32'h1, {31'h0, ser});
      chkch(1'b0, TYPE_FREQ, 4'h1, 1'b0, 1'b0);
      chkch(1'b1, TYPE_FREQ, 4'h0, 1'b1, 1'b0);
      mode(LVL_4, RAMP_SERIAL, PPC_FOUR, TYPE_PHASE, TYPE_FREQ, 4'hB, 3'h1);
      chkch(1'b0, TYPE_PHASE, 4'h3, 1'b1, 1'b1);
      chkch(1'b1, TYPE_FREQ, 4'h1, 1'b1, 1'b0);
      rd(1'b0, IDX_STATUS, 32'h00000073);
      rd(1'b1, IDX_STATUS, 32'h00000031);
      mode(LVL_16, RAMP_SERIAL, 3'h2, TYPE_FREQ, TYPE_OFF, 4'h5, 3'h1);
      chkch(1'b0, TYPE_FREQ, 4'hA, 1'b1, 1'b1);
      chkch(1'b1, TYPE_OFF, 4'h0, 1'b0, 1'b0);
      // Only a serial pin moves: the ramp direction follows, the index must not
      @(posedge clk_i);
      cmd_aux <= 3'h0;
      repeat (12) @(posedge clk_i);
      #1;
      chkch(1'b0, TYPE_FREQ, 4'hA, 1'b1, 1'b0);
      end_sim;
   end
endmodule : tb_top
